//--- design/rss_core.sv
// Purpose: per-channel receive robbed-bit signaling substitution and extraction
// Assumes: framer logic on clk presents one channel octet per beat
// Notes: sig_idx 0..3 names the robbed bit A..D carried in the octet lsb
// Operation
// - format 00 with substitution on forces every signaling bit to one.
// - format 01 replaces A,B,C,D with substitution values bits 3..0.
// - format 10 replaces A and B from substitution values bits 5 and 4.
// - format 11 replaces A from substitution values bit 6.
// - extraction format 00 extracts nothing for that channel.
// - extraction format 01 extracts A,B,C,D.
// - extraction format 10 extracts only A and B.
// - extraction format 11 extracts only A.
// - extracted bits go to array, signaling pin if enabled, overhead if enabled.
// - substitution touches PCM output only; array and pin keep received bits.
// - debounce on updates only after two identical superframes, else on change.
// - overhead output carries array contents only while its enable is set.
`timescale 1ns/10ps
`default_nettype none
`include "rss_params.svh"

module rss_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = `RSS_FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // pointer wrap arithmetic only works for a power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_fifo_cfg
    $error("rss_fifo: DEPTH must be a power of two >= 2 and WIDTH >= 1");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr_reg != rd_ptr_reg;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule

module rss_core #(
  parameter int NCH   = `RSS_NCH,
  parameter int DEPTH = `RSS_FIFO_DEPTH
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              cfg_we,
  input  wire logic [4:0]        cfg_chan,
  input  wire rss_pkg::rss_cfg_s cfg_wdata,
  input  wire logic              sig_if_en,
  input  wire logic              in_valid,
  output logic                   in_ready,
  input  wire rss_pkg::rss_pcm_s in_pcm,
  input  wire logic              in_sig_frame,
  input  wire logic [1:0]        in_sig_idx,
  input  wire logic              in_sf_last,
  output logic                   rx_pcm_out_valid,
  input  wire logic              rx_pcm_out_ready,
  output rss_pkg::rss_pcm_s      rx_pcm_out,
  output logic                   rx_sig_out_valid,
  output rss_pkg::rss_sig_s      rx_sig_out_pin,
  output logic                   rx_overhead_out_valid,
  output rss_pkg::rss_sig_s      rx_overhead_out_pin,
  input  wire logic [4:0]        rd_chan,
  output logic      [3:0]        rx_sig_array_reg
);
  if (NCH < 1 || NCH > 32) begin : g_bad_nch
    $error("rss_core: NCH must be 1..32");
  end

  logic              rst_s1_reg;
  logic              rst_s_b;
  rss_pkg::rss_cfg_s cfg_mem [NCH];
  logic [3:0]        acc_mem [NCH];
  logic [3:0]        prev_mem [NCH];
  logic [3:0]        arr_mem [NCH];
  rss_pkg::rss_cfg_s cur;
  rss_pkg::rss_pcm_s pcm_next;
  logic [3:0]        rx_abcd;
  logic [3:0]        ext_next;
  logic              take;
  logic              stable;
  logic              upd_next;
  logic [4:0]        ch;

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_reg <= 1'b0;
      rst_s_b    <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s_b    <= rst_s1_reg;
    end
  end

  function automatic logic sub_bit(input rss_pkg::rss_cfg_s c, input logic [1:0] idx, input logic rx);
    logic r;
    r = rx;
    case (c.rx_sig_sub_format)
      rss_pkg::RSS_SUB_ONES: r = 1'b1;
      rss_pkg::RSS_SUB_16:   r = c.rx_sig_sub_values_reg[`RSS_SV_A16 - idx];
      rss_pkg::RSS_SUB_4: begin
        if (idx == 2'd0) r = c.rx_sig_sub_values_reg[`RSS_SV_A4];
        if (idx == 2'd1) r = c.rx_sig_sub_values_reg[`RSS_SV_B4];
      end
      rss_pkg::RSS_SUB_2: begin
        if (idx == 2'd0) r = c.rx_sig_sub_values_reg[`RSS_SV_A2];
      end
      default: r = rx;
    endcase
    return r;
  endfunction

  function automatic logic [3:0] ext_mask(input rss_pkg::rss_ext_e f);
    case (f)
      rss_pkg::RSS_EXT_ABCD: return 4'hF;
      rss_pkg::RSS_EXT_AB:   return 4'hC;
      rss_pkg::RSS_EXT_A:    return 4'h8;
      default:               return 4'h0;
    endcase
  endfunction

  assign ch   = (int'(in_pcm.chan) < NCH) ? in_pcm.chan : 5'h00;
  assign cur  = cfg_mem[ch];
  assign take = in_valid && in_ready;

  // received abcd of this superframe, with this beat's bit merged in
  always_comb begin
    rx_abcd = acc_mem[ch];
    if (in_sig_frame) rx_abcd[3 - in_sig_idx] = in_pcm.octet[0];
  end

  always_comb begin
    pcm_next = in_pcm;
    if (in_sig_frame && cur.sig_sub_en) begin
      pcm_next.octet[0] = sub_bit(cur, in_sig_idx, in_pcm.octet[0]);
    end
  end

  assign ext_next = rx_abcd & ext_mask(cur.rx_sig_extract_format);
  assign stable   = ext_next == prev_mem[ch];
  // no signaling update leaves a channel with extraction off; its pcm octets still pass
  assign upd_next = take && in_sf_last && (cur.rx_sig_extract_format != rss_pkg::RSS_EXT_NONE) &&
                    (cur.sig_debounce_en ? stable : (ext_next != arr_mem[ch]));

  // per-channel settings, formats cleared at reset
  always_ff @(posedge clk or negedge rst_s_b) begin
    if (!rst_s_b) begin
      for (int i = 0; i < NCH; i++) begin
        cfg_mem[i] <= '{rx_sig_sub_format: rss_pkg::rss_sub_e'(`RSS_FMT_RST),
                        rx_sig_extract_format: rss_pkg::rss_ext_e'(`RSS_FMT_RST), default: '0};
      end
    end else if (cfg_we && int'(cfg_chan) < NCH) begin
      cfg_mem[cfg_chan] <= cfg_wdata;
    end
  end

  // accumulation and array use the received bits only
  always_ff @(posedge clk or negedge rst_s_b) begin
    if (!rst_s_b) begin
      for (int i = 0; i < NCH; i++) begin
        acc_mem[i]  <= 4'h0;
        prev_mem[i] <= 4'h0;
        arr_mem[i]  <= 4'h0;
      end
    end else if (take) begin
      acc_mem[ch] <= rx_abcd;
      if (in_sf_last) begin
        prev_mem[ch] <= ext_next;
        if (upd_next) arr_mem[ch] <= ext_next;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_s_b) begin
    if (!rst_s_b) begin
      rx_sig_out_valid      <= 1'b0;
      rx_sig_out_pin        <= '0;
      rx_overhead_out_valid <= 1'b0;
      rx_overhead_out_pin   <= '0;
      rx_sig_array_reg      <= 4'h0;
    end else begin
      rx_sig_out_valid      <= upd_next && sig_if_en;
      rx_overhead_out_valid <= upd_next && cur.overhead_sig_out_en;
      if (upd_next && sig_if_en) rx_sig_out_pin <= '{chan: ch, abcd: ext_next};
      if (upd_next && cur.overhead_sig_out_en) rx_overhead_out_pin <= '{chan: ch, abcd: ext_next};
      rx_sig_array_reg <= (int'(rd_chan) < NCH) ? arr_mem[rd_chan] : 4'h0;
    end
  end

  rss_fifo #(.WIDTH($bits(rss_pkg::rss_pcm_s)), .DEPTH(DEPTH)) u_fifo (
    .clk       (clk),
    .rst_b     (rst_s_b),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   (pcm_next),
    .out_valid (rx_pcm_out_valid),
    .out_ready (rx_pcm_out_ready),
    .out_data  (rx_pcm_out)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_s_b);

  a_sub_ones_bit: assert property (in_sig_frame && cur.sig_sub_en && cur.rx_sig_sub_format == rss_pkg::RSS_SUB_ONES
    |-> pcm_next.octet[0]) else $error("all-ones substitution missed");
  a_sub_sixteen: assert property (in_sig_frame && cur.sig_sub_en && cur.rx_sig_sub_format == rss_pkg::RSS_SUB_16
    |-> pcm_next.octet[0] == cur.rx_sig_sub_values_reg[3 - in_sig_idx]) else $error("16-code value wrong");
  a_sub_four: assert property (in_sig_frame && cur.sig_sub_en && cur.rx_sig_sub_format == rss_pkg::RSS_SUB_4
    && in_sig_idx == 2'd1 |-> pcm_next.octet[0] == cur.rx_sig_sub_values_reg[4]) else $error("4-code B wrong");
  a_sub_two: assert property (in_sig_frame && cur.sig_sub_en && cur.rx_sig_sub_format == rss_pkg::RSS_SUB_2
    && in_sig_idx != 2'd0 |-> pcm_next.octet[0] == in_pcm.octet[0]) else $error("2-code touched B..D");
  a_ext_none: assert property (take && in_sf_last && cur.rx_sig_extract_format == rss_pkg::RSS_EXT_NONE
    |=> !rx_sig_out_valid && !rx_overhead_out_valid) else $error("extraction while off");
  a_ext_ab_mask: assert property (upd_next && sig_if_en && cur.rx_sig_extract_format == rss_pkg::RSS_EXT_AB
    |=> rx_sig_out_pin.abcd[1:0] == 2'h0) else $error("4-code extraction leaked C,D");
  a_ext_a_mask: assert property (upd_next && sig_if_en && cur.rx_sig_extract_format == rss_pkg::RSS_EXT_A
    |=> rx_sig_out_pin.abcd[2:0] == 3'h0) else $error("2-code extraction leaked B..D");
  a_pin_gated: assert property (rx_sig_out_valid |-> $past(sig_if_en)) else $error("pin out while disabled");
  a_oh_gated: assert property (upd_next && !cur.overhead_sig_out_en |=> !rx_overhead_out_valid)
    else $error("overhead out while disabled");
  a_deb_hold: assert property (take && in_sf_last && cur.sig_debounce_en && ext_next != prev_mem[ch]
    |=> !rx_sig_out_valid && !rx_overhead_out_valid) else $error("debounce updated early");
  a_fifo_stall: assert property (rx_pcm_out_valid && !rx_pcm_out_ready |=> rx_pcm_out_valid && $stable(rx_pcm_out))
    else $error("pcm output dropped under stall");

  c_sub_sixteen: cover property (take && in_sig_frame && cur.sig_sub_en && cur.rx_sig_sub_format == rss_pkg::RSS_SUB_16);
  c_sig_update: cover property (rx_sig_out_valid && rx_overhead_out_valid);
  c_deb_stable: cover property (upd_next && cur.sig_debounce_en);
  c_fifo_full: cover property (!in_ready ##1 in_ready);
endmodule
`default_nettype wire

//--- pkg/rss_params.svh
// Purpose: constants for the receive signaling substitution/extraction block
// Assumes: one T1 receive framer, 24 timeslot channels
// Notes: definitions only
`ifndef RSS_PARAMS_SVH
`define RSS_PARAMS_SVH
`define RSS_NCH        24
`define RSS_FIFO_DEPTH 16
`define RSS_DEB_SF     2
`define RSS_FMT_RST    2'h0
`define RSS_SV_A16     3
`define RSS_SV_A4      5
`define RSS_SV_B4      4
`define RSS_SV_A2      6
`define RSS_SV_W       7
`endif

//--- pkg/rss_pkg.sv
// Purpose: shared types of the receive signaling substitution/extraction block
// Assumes: rss_params.svh holds the numbers
// Notes: nothing is imported; users write rss_pkg::name
`include "rss_params.svh"
package rss_pkg;
  typedef enum logic [1:0] {
    RSS_SUB_ONES = 2'b00,
    RSS_SUB_16   = 2'b01,
    RSS_SUB_4    = 2'b10,
    RSS_SUB_2    = 2'b11
  } rss_sub_e;

  typedef enum logic [1:0] {
    RSS_EXT_NONE = 2'b00,
    RSS_EXT_ABCD = 2'b01,
    RSS_EXT_AB   = 2'b10,
    RSS_EXT_A    = 2'b11
  } rss_ext_e;

  typedef struct packed {
    rss_sub_e                rx_sig_sub_format;
    rss_ext_e                rx_sig_extract_format;
    logic                    sig_sub_en;
    logic                    overhead_sig_out_en;
    logic                    sig_debounce_en;
    logic [`RSS_SV_W-1:0]    rx_sig_sub_values_reg;
  } rss_cfg_s;

  typedef struct packed {
    logic [4:0] chan;
    logic [7:0] octet;
  } rss_pcm_s;

  typedef struct packed {
    logic [4:0] chan;
    logic [3:0] abcd;
  } rss_sig_s;
endpackage

//--- test/rss_pcm_sink.sv
// Purpose: downstream pcm backplane consumer model
// Assumes: valid/ready handshake on clk
// Notes: slow mode accepts only every other cycle
`timescale 1ns/10ps
`default_nettype none
module rss_pcm_sink (
  input  wire logic              clk,
  input  wire logic              stall,
  input  wire logic              slow,
  input  wire logic              valid,
  input  wire rss_pkg::rss_pcm_s data,
  output logic                   ready
);
  rss_pkg::rss_pcm_s q[$];
  logic              ph = 1'b0;
  // ready may drop while a word waits, as a real backplane can
  assign ready = !stall && (!slow || ph);
  always @(posedge clk) begin
    ph <= ~ph;
    if (valid && ready) begin
      q.push_back(data);
    end
  end
endmodule
`default_nettype wire

//--- test/rx_signaling_subst_extract_tb_top.sv
// Purpose: self-checking bench for rss_core
// Assumes: inputs driven on the falling edge of clk
// Notes: a mirror of each channel's settings predicts the pcm stream
`timescale 1ns/10ps
`default_nettype none
`include "rss_params.svh"
module rx_signaling_subst_extract_tb_top;
  logic              clk, in_ready, pv, pr, sv, ov;
  logic              rst_b = 1'b0, cfg_we = 1'b0, sig_if_en = 1'b1, in_valid = 1'b0;
  logic              in_sig_frame = 1'b0, in_sf_last = 1'b0, stall = 1'b0, slow = 1'b0;
  logic [4:0]        cfg_chan = 5'h00, rd_chan = 5'h00;
  logic [1:0]        in_sig_idx = 2'h0;
  logic [3:0]        arr;
  rss_pkg::rss_cfg_s cfg_wdata = '0, mir[`RSS_NCH];
  rss_pkg::rss_pcm_s in_pcm = '0, pcm, expq[$];
  rss_pkg::rss_sig_s spin, opin;
  int                err_count = 0, comparisons = 0, cyc = 0, nsig = 0, noh = 0;

  rss_core rss_core_i (.clk(clk), .rst_b(rst_b), .cfg_we(cfg_we), .cfg_chan(cfg_chan), .cfg_wdata(cfg_wdata),
    .sig_if_en(sig_if_en), .in_valid(in_valid), .in_ready(in_ready), .in_pcm(in_pcm), .in_sig_frame(in_sig_frame),
    .in_sig_idx(in_sig_idx), .in_sf_last(in_sf_last), .rx_pcm_out_valid(pv), .rx_pcm_out_ready(pr),
    .rx_pcm_out(pcm), .rx_sig_out_valid(sv), .rx_sig_out_pin(spin), .rx_overhead_out_valid(ov),
    .rx_overhead_out_pin(opin), .rd_chan(rd_chan), .rx_sig_array_reg(arr));
  rss_pcm_sink rss_pcm_sink_i (.clk(clk), .stall(stall), .slow(slow), .valid(pv), .data(pcm), .ready(pr));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    nsig += int'(sv);
    noh += int'(ov);
    if (cyc == 20000) begin
      err_count++;
      give_verdict;
    end
  end

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cfg(int ch, logic [1:0] sf, logic [1:0] ef, logic [2:0] en, logic [6:0] v);
    cfg_we = 1'b1;
    cfg_chan = ch[4:0];
    cfg_wdata = {sf, ef, en, v};
    mir[ch] = {sf, ef, en, v};
    @(negedge clk);
    cfg_we = 1'b0;
  endtask
  function automatic logic [7:0] exp_oct(rss_pkg::rss_pcm_s p, logic s, logic [1:0] i);
    rss_pkg::rss_cfg_s c;
    logic              b;
    c = mir[p.chan];
    b = p.octet[0];
    if (s && c.sig_sub_en) begin
      case (c.rx_sig_sub_format)
        rss_pkg::RSS_SUB_ONES: b = 1'b1;
        rss_pkg::RSS_SUB_16: b = c.rx_sig_sub_values_reg[3 - i];
        rss_pkg::RSS_SUB_4: if (i < 2) b = c.rx_sig_sub_values_reg[5 - i];
        default: if (i == 0) b = c.rx_sig_sub_values_reg[6];
      endcase
    end
    return {p.octet[7:1], b};
  endfunction
  // valid stays up between calls so beats can run back to back
  task automatic beat(int ch, logic [7:0] oct, logic s, logic [1:0] i, logic last);
    int n;
    in_valid = 1'b1;
    in_pcm = {ch[4:0], oct};
    in_sig_frame = s;
    in_sig_idx = i;
    in_sf_last = last;
    for (n = 0; n < 100 && in_ready !== 1'b1; n++) begin
      @(negedge clk);
    end
    chk("in_ready wait", 16'(n == 100), 16'h0000);
    expq.push_back({ch[4:0], exp_oct(in_pcm, s, i)});
    @(negedge clk);
  endtask
  task automatic sframe(int ch, logic [3:0] abcd);
    for (int i = 0; i < 4; i++) begin
      beat(ch, {7'h2A, abcd[3 - i]}, 1'b1, i[1:0], i == 3);
    end
    beat(ch, 8'hC3, 1'b0, 2'h0, 1'b0);
    in_valid = 1'b0;
  endtask
  task automatic drain;
    for (int n = 0; n < 500 && rss_pcm_sink_i.q.size() < expq.size(); n++) begin
      @(negedge clk);
    end
    chk("pcm count", 16'(rss_pcm_sink_i.q.size()), 16'(expq.size()));
    while (expq.size() > 0 && rss_pcm_sink_i.q.size() > 0) begin
      chk("pcm word", 16'(rss_pcm_sink_i.q.pop_front()), 16'(expq.pop_front()));
    end
  endtask
  task automatic sig_check(int ch, int es, int eo, logic [3:0] ea);
    repeat (4) @(negedge clk);
    rd_chan = ch[4:0];
    @(negedge clk);
    chk("sig pulses", 16'(nsig), 16'(es));
    chk("oh pulses", 16'(noh), 16'(eo));
    chk("array", {12'h000, arr}, {12'h000, ea});
    if (es > 0) chk("sig pin", 16'(spin), {7'h00, ch[4:0], ea});
    if (eo > 0) chk("oh pin", 16'(opin), {7'h00, ch[4:0], ea});
    nsig = 0;
    noh = 0;
  endtask

  task automatic t_reset;
    chk("ready after reset", 16'(in_ready), 16'h0001);
    sframe(0, 4'h5);
    sig_check(0, 0, 0, 4'h0);
    drain;
  endtask
  task automatic t_sub;
    slow = 1'b1;
    for (int f = 0; f < 4; f++) begin
      cfg(f + 1, f[1:0], 2'h0, 3'h4, 7'h6D);
      sframe(f + 1, 4'h2);
    end
    drain;
    slow = 1'b0;
  endtask
  task automatic t_ext;
    logic [3:0] m[4] = '{4'h0, 4'hD, 4'hC, 4'h8};
    for (int e = 0; e < 4; e++) begin
      cfg(10 + e, 2'h0, e[1:0], {2'b11, 1'b0} & {1'b1, e[0], 1'b0}, 7'h00);
      sframe(10 + e, 4'hD);
      sframe(10 + e, 4'hD);
      sig_check(10 + e, int'(e != 0), int'(e % 2 == 1), m[e]);
    end
    drain;
  endtask
  task automatic t_deb;
    cfg(20, 2'h0, 2'h1, 3'h3, 7'h00);
    sframe(20, 4'h6);
    sig_check(20, 0, 0, 4'h0);
    sframe(20, 4'h6);
    sig_check(20, 1, 1, 4'h6);
    sframe(20, 4'h9);
    sig_check(20, 0, 0, 4'h6);
    // pin interface off: array and overhead still update
    sig_if_en = 1'b0;
    sframe(20, 4'h9);
    sig_check(20, 0, 1, 4'h9);
    sig_if_en = 1'b1;
    drain;
  endtask
  task automatic t_fifo;
    stall = 1'b1;
    for (int i = 0; i < `RSS_FIFO_DEPTH; i++) begin
      beat(3, 8'(i), 1'b0, 2'h0, 1'b0);
    end
    in_valid = 1'b0;
    chk("ready when full", 16'(in_ready), 16'h0000);
    stall = 1'b0;
    drain;
    chk("empty after drain", 16'(pv), 16'h0000);
  endtask

  initial begin
    foreach (mir[k]) mir[k] = '0;
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    t_reset;
    t_sub;
    t_ext;
    t_deb;
    t_fifo;
    give_verdict;
  end
endmodule
`default_nettype wire
